// [sse_pkg.sv]
// shared constants and types for the soft starter status encoder
// assumes a single 250 MHz clock and an apb master with 32-bit data
package sse_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_STATE_CODE = 8'h00;
    localparam logic [7:0] OFS_CMD_SOURCE = 8'h04;
    localparam logic [7:0] OFS_COND_WORD = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0c;

    // ==========================================================
    // status word bit positions
    localparam int BIT_RUNNING = 0;
    localparam int BIT_ENABLED = 1;
    localparam int BIT_INCHING = 2;
    localparam int BIT_INIT_TEST = 3;
    localparam int BIT_RAMP_UP = 4;
    localparam int BIT_FULL_VOLT = 5;
    localparam int BIT_BYPASS = 6;
    localparam int BIT_RAMP_DOWN = 7;
    localparam int BIT_REMOTE = 8;
    localparam int BIT_BRAKING = 9;
    localparam int BIT_REVERSAL = 10;
    localparam int BIT_REVERSE = 11;
    localparam int BIT_START_DLY = 12;
    localparam int BIT_STOP_DLY = 13;
    localparam int BIT_ALARM = 14;
    localparam int BIT_FAULT = 15;

    // control register: bit 0 holds the snapshot
    localparam int BIT_FREEZE = 0;

    // ==========================================================
    // reset values and the highest command source code
    localparam logic [3:0] RST_STATE_CODE = 4'h0;
    localparam logic [3:0] RST_CMD_SOURCE = 4'h0;
    localparam logic [15:0] RST_COND_WORD = 16'h0000;
    localparam logic RST_FREEZE = 1'b0;
    localparam logic [3:0] CMD_SOURCE_MAX = 4'hb;

    // ==========================================================
    // operating state codes
    typedef enum logic [3:0] {
        ST_READY = 4'h0,
        ST_INIT_TEST = 4'h1,
        ST_FAULT = 4'h2,
        ST_RAMP_UP = 4'h3,
        ST_FULL_VOLT = 4'h4,
        ST_BYPASS = 4'h5,
        ST_UNUSED = 4'h6,
        ST_RAMP_DOWN = 4'h7,
        ST_BRAKING = 4'h8,
        ST_REVERSAL = 4'h9,
        ST_INCHING = 4'ha,
        ST_START_DLY = 4'hb,
        ST_RESTART_DLY = 4'hc,
        ST_DISABLED = 4'hd,
        ST_CONFIG = 4'he
    } sse_state_type;

    // origin of start and stop commands
    typedef enum logic [2:0] {
        ORG_OPERATOR_PANEL = 3'h0,
        ORG_DIGITAL_INPUT_SOURCE = 3'h1,
        ORG_USB = 3'h2,
        ORG_EMBEDDED_LOGIC = 3'h3,
        ORG_SLOT_ONE = 3'h4,
        ORG_SLOT_TWO = 3'h5
    } sse_origin_type;

    // live conditions from the motor controller
    typedef struct packed {
        logic running;
        logic all_enabled;
        logic inching;
        logic init_test;
        logic accelerating;
        logic full_voltage;
        logic bypass_closed;
        logic decelerating;
        logic braking;
        logic direction_reversal;
        logic reverse_dir;
        logic start_delay;
        logic restart_delay;
        logic alarm;
        logic fault;
        logic config_mode;
        logic remote_control;
        sse_origin_type origin;
    } sse_cond_type;

    // apb request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } sse_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sse_apb_rsp_type;

endpackage

// [sse_status_encoder.sv]
// status reporting logic of a motor soft starter: state code,
// command source code and condition word, readable over apb
// assumes drive conditions come from logic on the same mclk
//
// Function
// R1: codes 0-5: ready, test, fault, ramp, full, bypass
// R2: 6 unused; 7-13 decel, brake, reverse, inch, delays, disabled
// R3: code 14 during configuration mode
// R4: command source code origin pairs, odd means remote
// R5: bit 0 set while motor enabled
// R6: bit 1 set only when all enables granted
// R7: bit 2 set while inching active
// R8: bit 3 set during initial tests
// R9: bit 4 set during whole acceleration ramp
// R10: bit 5 set while full voltage applied
// R11: bit 6 set while bypass contactor closed
// R12: bit 7 set during whole deceleration ramp
// R13: bit 9 set throughout braking
// R14: bit 10 set during direction reversal process
// R15: bit 12 set while pre-start delay runs
// R16: bit 13 set while post-stop delay runs
// R17: bit 14 set while any alarm active
// R18: bit 15 set while in fault condition
// R19: all three indications updated together from one state
// R20: bit 8 local or remote, bit 11 direction
`timescale 1ns/1ns
module sse_status_encoder
    import sse_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire sse_cond_type drive_cond,
    input wire sse_apb_req_type apb_req,
    output sse_apb_rsp_type apb_rsp,
    output logic [3:0] state_code,
    output logic [3:0] cmd_source,
    output logic [15:0] cond_word
);

    // ==========================================================
    // address decode

    // true when the request address selects the given register
    function automatic logic sse_hit(input logic [7:0] addr, input logic [7:0] ofs);
        sse_hit = (addr == ofs);
    endfunction

    logic freeze_q;
    logic [3:0] state_code_q;
    logic [3:0] cmd_source_q;
    logic [15:0] cond_word_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;

    wire hit_state = sse_hit(apb_req.paddr, OFS_STATE_CODE);
    wire hit_cmd = sse_hit(apb_req.paddr, OFS_CMD_SOURCE);
    wire hit_word = sse_hit(apb_req.paddr, OFS_COND_WORD);
    wire hit_ctrl = sse_hit(apb_req.paddr, OFS_CONTROL);
    wire hit_any = hit_state | hit_cmd | hit_word | hit_ctrl;

    // bus phases
    wire setup_ph = apb_req.psel & ~apb_req.penable;
    wire access_ph = apb_req.psel & apb_req.penable;
    wire ctrl_wr = access_ph & apb_req.pwrite & hit_ctrl & apb_req.pstrb[0];

    // ==========================================================
    // state code selection, highest priority first

    // fault wins so the fault flag and code 2 always agree
    wire sse_state_type state_d =
        drive_cond.fault ? ST_FAULT : // R1
        drive_cond.config_mode ? ST_CONFIG : // R3
        !drive_cond.all_enabled ? ST_DISABLED : // R2
        drive_cond.init_test ? ST_INIT_TEST : // R1
        drive_cond.braking ? ST_BRAKING : // R2
        drive_cond.direction_reversal ? ST_REVERSAL : // R2
        drive_cond.inching ? ST_INCHING : // R2
        drive_cond.start_delay ? ST_START_DLY : // R2
        drive_cond.restart_delay ? ST_RESTART_DLY : // R2
        drive_cond.decelerating ? ST_RAMP_DOWN : // R2
        drive_cond.bypass_closed ? ST_BYPASS : // R1
        drive_cond.full_voltage ? ST_FULL_VOLT : // R1
        drive_cond.accelerating ? ST_RAMP_UP : // R1
        ST_READY; // R1

    // ==========================================================
    // command source: origin pair plus remote in the low bit

    // an origin outside the six known ones falls back to the panel
    wire origin_ok = (drive_cond.origin <= ORG_SLOT_TWO);
    wire [2:0] origin_sel = origin_ok ? drive_cond.origin : ORG_OPERATOR_PANEL;
    wire [3:0] cmd_d = {origin_sel, drive_cond.remote_control}; // R4

    // ==========================================================
    // condition word assembly
    logic [15:0] word_d;

    always_comb
    begin
        word_d = RST_COND_WORD;
        word_d[BIT_RUNNING] = drive_cond.running; // R5
        word_d[BIT_ENABLED] = drive_cond.all_enabled; // R6
        word_d[BIT_INCHING] = drive_cond.inching; // R7
        word_d[BIT_INIT_TEST] = drive_cond.init_test; // R8
        word_d[BIT_RAMP_UP] = drive_cond.accelerating; // R9
        word_d[BIT_FULL_VOLT] = drive_cond.full_voltage; // R10
        word_d[BIT_BYPASS] = drive_cond.bypass_closed; // R11
        word_d[BIT_RAMP_DOWN] = drive_cond.decelerating; // R12
        word_d[BIT_REMOTE] = drive_cond.remote_control; // R20
        word_d[BIT_BRAKING] = drive_cond.braking; // R13
        word_d[BIT_REVERSAL] = drive_cond.direction_reversal; // R14
        word_d[BIT_REVERSE] = drive_cond.reverse_dir; // R20
        word_d[BIT_START_DLY] = drive_cond.start_delay; // R15
        word_d[BIT_STOP_DLY] = drive_cond.restart_delay; // R16
        word_d[BIT_ALARM] = drive_cond.alarm; // R17
        word_d[BIT_FAULT] = drive_cond.fault; // R18
    end

    // ==========================================================
    // snapshot: all three indications move on the same edge

    // holding stops updates so software can read a frozen set
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_code_q <= RST_STATE_CODE;
            cmd_source_q <= RST_CMD_SOURCE;
            cond_word_q <= RST_COND_WORD;
        end
        else if (!freeze_q)
        begin
            state_code_q <= state_d; // R19
            cmd_source_q <= cmd_d; // R19
            cond_word_q <= word_d; // R19
        end
    end

    // ==========================================================
    // control register

    // bit 0 holds the snapshot while set
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            freeze_q <= RST_FREEZE;
        else if (ctrl_wr)
            freeze_q <= apb_req.pwdata[BIT_FREEZE];
    end

    // ==========================================================
    // read data and error, captured in the setup cycle

    // unmapped addresses read zero and flag an error
    always_comb
    begin
        prdata_d = 32'h0000_0000;
        if (hit_state)
            prdata_d[3:0] = state_code_q;
        else if (hit_cmd)
            prdata_d[3:0] = cmd_source_q;
        else if (hit_word)
            prdata_d[15:0] = cond_word_q;
        else if (hit_ctrl)
            prdata_d[BIT_FREEZE] = freeze_q;
        pslverr_d = ~hit_any;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata_q <= apb_req.pwrite ? 32'h0000_0000 : prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ==========================================================
    // outputs

    // zero wait states: every access phase completes at once
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.prdata = prdata_q;
    assign apb_rsp.pslverr = pslverr_q & access_ph;
    assign state_code = state_code_q;
    assign cmd_source = cmd_source_q;
    assign cond_word = cond_word_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // a fault shows as code 2 and bit 15 on the next edge
    property p_fault_code;
        !freeze_q && drive_cond.fault
            |=> state_code_q == ST_FAULT && cond_word_q[BIT_FAULT];
    endproperty
    a_fault_code: assert property (p_fault_code) // R18
        else $error("fault not shown as code 2 with bit 15");

    // the fault flag and code 2 never disagree
    property p_fault_agree;
        cond_word_q[BIT_FAULT] == (state_code_q == ST_FAULT);
    endproperty
    a_fault_agree: assert property (p_fault_agree) // R19
        else $error("fault flag and state code disagree");

    // configuration without fault shows code 14
    property p_config;
        !freeze_q && !drive_cond.fault && drive_cond.config_mode
            |=> state_code_q == ST_CONFIG;
    endproperty
    a_config: assert property (p_config) // R3
        else $error("configuration mode not shown as code 14");

    // code 6 is never produced and nothing lies above 14
    property p_code_range;
        state_code_q != ST_UNUSED && state_code_q <= ST_CONFIG;
    endproperty
    a_code_range: assert property (p_code_range) // R2
        else $error("state code out of range or unused");

    // source code stays in range, parity matches bit 8
    property p_cmd_parity;
        cmd_source_q <= CMD_SOURCE_MAX
            && cmd_source_q[0] == cond_word_q[BIT_REMOTE];
    endproperty
    a_cmd_parity: assert property (p_cmd_parity) // R4
        else $error("command source code inconsistent");

    // running flag follows the motor enable one edge later
    property p_running;
        !freeze_q |=> cond_word_q[BIT_RUNNING] == $past(drive_cond.running);
    endproperty
    a_running: assert property (p_running) // R5
        else $error("running flag did not follow the motor");

    // general disable state never shows the enable flag
    property p_disabled;
        state_code_q == ST_DISABLED |-> !cond_word_q[BIT_ENABLED];
    endproperty
    a_disabled: assert property (p_disabled) // R6
        else $error("enable flag set while disabled");

    // ramp up state always carries the acceleration flag
    property p_ramp_up;
        state_code_q == ST_RAMP_UP |-> cond_word_q[BIT_RAMP_UP];
    endproperty
    a_ramp_up: assert property (p_ramp_up) // R9
        else $error("ramp up state without acceleration flag");

    // bypass state always carries the bypass flag
    property p_bypass;
        state_code_q == ST_BYPASS |-> cond_word_q[BIT_BYPASS];
    endproperty
    a_bypass: assert property (p_bypass) // R11
        else $error("bypass state without bypass flag");

    // reversal state always carries the reversal flag
    property p_reversal;
        state_code_q == ST_REVERSAL |-> cond_word_q[BIT_REVERSAL];
    endproperty
    a_reversal: assert property (p_reversal) // R14
        else $error("reversal state without reversal flag");

    // a held snapshot does not move
    property p_hold;
        freeze_q |=> $stable(cond_word_q) && $stable(state_code_q)
            && $stable(cmd_source_q);
    endproperty
    a_hold: assert property (p_hold) // R19
        else $error("snapshot changed while held");

    // a word read returns the word seen in the setup cycle
    property p_word_read;
        setup_ph && !apb_req.pwrite && hit_word
            |=> apb_rsp.prdata == {16'h0000, $past(cond_word_q)};
    endproperty
    a_word_read: assert property (p_word_read) // R19
        else $error("condition word read returned wrong data");

    // initial tests with nothing of higher priority show code 1
    property p_init_state;
        !freeze_q && drive_cond.init_test && drive_cond.all_enabled && !drive_cond.fault
            && !drive_cond.config_mode |=> state_code_q == ST_INIT_TEST;
    endproperty
    a_init_state: assert property (p_init_state) // R1
        else $error("initial tests not shown as code 1");

    // enable flag follows the enable sources one edge later
    property p_enabled;
        !freeze_q |=> cond_word_q[BIT_ENABLED] == $past(drive_cond.all_enabled);
    endproperty
    a_enabled: assert property (p_enabled) // R6
        else $error("enable flag did not follow the enable sources");

    // inching flag follows the inching function one edge later
    property p_inching;
        !freeze_q |=> cond_word_q[BIT_INCHING] == $past(drive_cond.inching);
    endproperty
    a_inching: assert property (p_inching) // R7
        else $error("inching flag did not follow the function");

    // initial test flag follows the tests one edge later
    property p_init_test;
        !freeze_q |=> cond_word_q[BIT_INIT_TEST] == $past(drive_cond.init_test);
    endproperty
    a_init_test: assert property (p_init_test) // R8
        else $error("initial test flag did not follow the tests");

    // full voltage flag follows the output one edge later
    property p_full_volt;
        !freeze_q |=> cond_word_q[BIT_FULL_VOLT] == $past(drive_cond.full_voltage);
    endproperty
    a_full_volt: assert property (p_full_volt) // R10
        else $error("full voltage flag did not follow the output");

    // deceleration flag follows the ramp one edge later
    property p_ramp_down;
        !freeze_q |=> cond_word_q[BIT_RAMP_DOWN] == $past(drive_cond.decelerating);
    endproperty
    a_ramp_down: assert property (p_ramp_down) // R12
        else $error("deceleration flag did not follow the ramp");

    // braking flag follows the brake one edge later
    property p_braking;
        !freeze_q |=> cond_word_q[BIT_BRAKING] == $past(drive_cond.braking);
    endproperty
    a_braking: assert property (p_braking) // R13
        else $error("braking flag did not follow the brake");

    // pre-start delay flag follows its timer one edge later
    property p_start_dly;
        !freeze_q |=> cond_word_q[BIT_START_DLY] == $past(drive_cond.start_delay);
    endproperty
    a_start_dly: assert property (p_start_dly) // R15
        else $error("pre-start delay flag did not follow its timer");

    // post-stop delay flag follows its timer one edge later
    property p_stop_dly;
        !freeze_q |=> cond_word_q[BIT_STOP_DLY] == $past(drive_cond.restart_delay);
    endproperty
    a_stop_dly: assert property (p_stop_dly) // R16
        else $error("post-stop delay flag did not follow its timer");

    // alarm flag follows the alarm summary one edge later
    property p_alarm;
        !freeze_q |=> cond_word_q[BIT_ALARM] == $past(drive_cond.alarm);
    endproperty
    a_alarm: assert property (p_alarm) // R17
        else $error("alarm flag did not follow the alarms");

    // remote flag follows the selection one edge later
    property p_remote;
        !freeze_q |=> cond_word_q[BIT_REMOTE] == $past(drive_cond.remote_control);
    endproperty
    a_remote: assert property (p_remote) // R20
        else $error("remote flag did not follow the selection");

    // direction flag follows the rotation one edge later
    property p_reverse;
        !freeze_q |=> cond_word_q[BIT_REVERSE] == $past(drive_cond.reverse_dir);
    endproperty
    a_reverse: assert property (p_reverse) // R20
        else $error("direction flag did not follow the rotation");

    // main scenarios
    c_fault: cover property (state_code_q == ST_FAULT);
    c_config: cover property (state_code_q == ST_CONFIG);
    c_slot_two_remote: cover property (cmd_source_q == CMD_SOURCE_MAX);
    c_held_read: cover property (freeze_q && access_ph && hit_word);

endmodule

// [sse_apb_host.sv]
// apb master model standing in for the panel or host that reads the status
// assumes the slave runs on the same mclk and pready is sampled at rising edges
`timescale 1ns/1ns
module sse_apb_host
    import sse_pkg::*;
(
    input wire logic mclk,
    input wire sse_apb_rsp_type rsp,
    output sse_apb_req_type req
);
    // ==========================================================
    // bus idle from time zero
    initial
    begin
        req = '0;
    end

    // one transfer: setup, access held until pready, then release
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge mclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= wd;
        req.pstrb <= 4'hf;
        @(posedge mclk);
        req.penable <= 1'b1;
        // only the bench watchdog ends a wait that never completes
        do
        begin
            @(posedge mclk);
        end
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        // released address and data lines must not keep the old value
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        req.paddr <= ~a;
        req.pwdata <= ~wd;
    endtask
endmodule

// [soft_starter_status_encoder_tb.sv]
// self-checking bench for the status encoder: outputs and apb reads
// assumes the encoder answers one edge after drive_cond and pready stays high
`timescale 1ns/1ns
module soft_starter_status_encoder_tb
    import sse_pkg::*;
();
    logic mclk;
    logic rst;
    sse_cond_type cond;
    sse_apb_req_type req;
    sse_apb_rsp_type rsp;
    logic [3:0] state_code;
    logic [3:0] cmd_source;
    logic [15:0] cond_word;
    int n_mismatch;
    int num_checks;
    logic [31:0] rd;
    logic err;
    sse_cond_type c;
    sse_cond_type c2;

    sse_status_encoder dut_u (.mclk(mclk), .rst(rst), .drive_cond(cond), .apb_req(req),
        .apb_rsp(rsp), .state_code(state_code), .cmd_source(cmd_source),
        .cond_word(cond_word));
    sse_apb_host host_u (.mclk(mclk), .rsp(rsp), .req(req));

    // ==========================================================
    // 250 mhz clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // expected state code, highest priority applied last
    function automatic logic [3:0] exp_state(input sse_cond_type k);
        logic [3:0] s;
        s = 4'h0;
        if (k.accelerating) s = 4'h3;
        if (k.full_voltage) s = 4'h4;
        if (k.bypass_closed) s = 4'h5;
        if (k.decelerating) s = 4'h7;
        if (k.restart_delay) s = 4'hc;
        if (k.start_delay) s = 4'hb;
        if (k.inching) s = 4'ha;
        if (k.direction_reversal) s = 4'h9;
        if (k.braking) s = 4'h8;
        if (k.init_test) s = 4'h1;
        if (!k.all_enabled) s = 4'hd;
        if (k.config_mode) s = 4'he;
        if (k.fault) s = 4'h2;
        return s;
    endfunction

    // expected condition word
    function automatic logic [15:0] exp_word(input sse_cond_type k);
        return {k.fault, k.alarm, k.restart_delay, k.start_delay, k.reverse_dir,
            k.direction_reversal, k.braking, k.remote_control, k.decelerating,
            k.bypass_closed, k.full_voltage, k.accelerating, k.init_test, k.inching,
            k.all_enabled, k.running};
    endfunction

    // expected command source: origin pair, unknown origins fall back to the panel
    function automatic logic [3:0] exp_cmd(input sse_cond_type k);
        logic [2:0] o;
        o = (k.origin > 3'h5) ? 3'h0 : k.origin;
        return {o, k.remote_control};
    endfunction

    // random conditions, each flag set about one time in eight, all_enabled about seven times in eight
    function automatic sse_cond_type rnd();
        logic [31:0] r;
        sse_cond_type k;
        r = $urandom & $urandom & $urandom;
        k = r[19:0];
        k.origin = sse_origin_type'($urandom_range(5));
        k.all_enabled = ($urandom % 8) != 0;
        return k;
    endfunction

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // drive conditions and check all three indications one edge later
    task automatic apply(input sse_cond_type k);
        @(posedge mclk);
        cond <= k;
        @(posedge mclk);
        @(negedge mclk);
        chk(state_code, exp_state(k), "state code");
        chk(cmd_source, exp_cmd(k), "command source");
        chk(cond_word, exp_word(k), "condition word");
    endtask

    // apb read with data and error check
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        host_u.xfer(1'b0, a, 32'h0, rd, err);
        chk(rd, e, "read data");
        chk({31'h0, err}, {31'h0, ee}, "slave error");
    endtask

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial
    begin
        #100000;
        n_mismatch++;
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        void'($urandom(4562));
        rst = 1'b1;
        cond = '0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        chk(state_code, RST_STATE_CODE, "reset state");
        chk(cond_word, RST_COND_WORD, "reset word");
        chk(rsp.prdata, 32'h0, "reset read data");
        @(posedge mclk);
        rst <= 1'b0;
        rdchk(OFS_CONTROL, 32'h0, 1'b0);
        // each condition alone, every origin and selection
        for (int i = 3; i < 20; i++)
        begin
            c = 20'h1 << i;
            c.all_enabled = 1'b1;
            c.origin = sse_origin_type'(i % 6);
            apply(c);
        end
        for (int k = 0; k < 16; k++)
        begin
            c = '0;
            c.origin = sse_origin_type'(k / 2);
            c.remote_control = k[0];
            apply(c);
        end
        // random conditions read back over the bus
        repeat (120)
        begin
            c = rnd();
            apply(c);
            rdchk(OFS_STATE_CODE, {28'h0, exp_state(c)}, 1'b0);
            rdchk(OFS_CMD_SOURCE, {28'h0, exp_cmd(c)}, 1'b0);
            rdchk(OFS_COND_WORD, {16'h0, exp_word(c)}, 1'b0);
        end
        // unmapped address and a write to a read-only place
        rdchk(8'h10, 32'h0, 1'b1);
        host_u.xfer(1'b1, OFS_STATE_CODE, 32'hffffffff, rd, err);
        rdchk(OFS_STATE_CODE, {28'h0, exp_state(c)}, 1'b0);
        // snapshot holds state code and condition word together
        host_u.xfer(1'b1, OFS_CONTROL, 32'h1, rd, err);
        rdchk(OFS_CONTROL, 32'h1, 1'b0);
        c2 = rnd();
        c2.fault = ~c.fault;
        @(posedge mclk);
        cond <= c2;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk(state_code, exp_state(c), "frozen state");
        chk(cond_word, exp_word(c), "frozen word");
        rdchk(OFS_COND_WORD, {16'h0, exp_word(c)}, 1'b0);
        // reset in mid-run releases the snapshot
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        rdchk(OFS_CONTROL, 32'h0, 1'b0);
        apply(c2);
        finish_test();
    end
endmodule
